// file: design/adc_ctrl_cfg.svh
// Contract
// - Every conversion yields a ten-bit result
// - Alignment bit places result in byte pair
// - Result bytes hold while converter is off
// - Start bit low-high-low begins a conversion
// - Busy flag set at start, cleared at end
// - Power enable switches converter on or off
// - Two gain bits pick internal reference level
// - Channel codes 0-3 pick pins, others float
// - Source field picks pin or internal signal
// - Reference field picks pin, supply or amplifier
// - Divider code halves conversion clock per step
// - One converter shared through one multiplexer
// - Analog pin drops digital function and pull-up
// - Conversion takes four sample plus ten convert
// - Completion raises request flag and gated interrupt
// - Bandgap on from its bit or low-voltage reset
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define ADC_ADDR_RES_LO   4'h0
`define ADC_ADDR_RES_HI   4'h4
`define ADC_ADDR_CTRL_A   4'h8
`define ADC_ADDR_CTRL_B   4'hC
`define ADC_ADDR_BANDGAP  5'h10
`define ADC_ADDR_IRQ      5'h14

// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define ADC_A_START       7
`define ADC_A_BUSY        6
`define ADC_A_PWR         5
`define ADC_A_ALIGN       4
`define ADC_A_GAIN_LO     3
`define ADC_B_GAIN_HI     5
`define ADC_BG_EN         3
`define ADC_CTRL_RST      8'h00
`define ADC_ZERO8         8'h00
`define ADC_ZERO32        32'h0000_0000

// -----------------------------------------------------------------
// Conversion timing in conversion clock periods
// -----------------------------------------------------------------
`define ADC_SAMPLE_TCK    5'h04
`define ADC_TOTAL_TCK     5'h0E

`endif

// file: design/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    // Conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;
    // Reference source encodings
    typedef enum logic [1:0] {
        REF_PIN    = 2'b00,
        REF_SUPPLY = 2'b01,
        REF_GAIN   = 2'b10,
        REF_PIN2   = 2'b11
    } ref_src_t;
endpackage

// file: design/adc_clk_div.sv
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"

// Conversion clock enable: one pulse every 2**code system clocks
module adc_clk_div #(
    parameter int CNT_W = 7
) (
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             run_i,
    input  wire logic [2:0]       code_i,
    output logic                  tick_o
);
    // Counter must span the slowest division by 128
    if (CNT_W < 7) begin : g_bad_width
        $error("adc_clk_div: CNT_W must reach 128");
    end

    logic [CNT_W-1:0] cnt_r;   // Free count while running
    logic [CNT_W-1:0] mask;    // Low bits that must be all ones

    // Mask of 2**code - 1
    always_comb begin
        mask = CNT_W'((8'h01 << code_i) - 8'h01);
    end

    // -----------------------------------------------------------------
    // Divider counter
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
        end else if (!run_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    // Code 0 gives a tick every cycle, code 7 every 128
    assign tick_o = run_i && ((cnt_r & mask) == mask);
endmodule

// file: design/adc_input_mux.sv
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"

// Analog routing selects for the single shared converter
module adc_input_mux (
    input  wire logic [1:0]       source_i,
    input  wire logic [2:0]       chan_i,
    input  wire logic [1:0]       ref_i,
    input  wire logic [3:0]       pin_analog_i,
    output logic [3:0]            pin_sel_o,
    output logic                  sel_amp_o,
    output logic                  sel_bat_o,
    output logic                  sel_supply_o,
    output logic                  ref_pin_o,
    output logic                  ref_supply_o,
    output logic                  ref_gain_o,
    output logic [3:0]            pin_digital_off_o,
    output logic [3:0]            pin_pullup_off_o
);
    genvar g;
    // Pin switch closes only for codes 0..3, whatever source is chosen
    generate
        for (g = 0; g < 4; g++) begin : g_pin
            assign pin_sel_o[g] = (chan_i == 3'(g));
            assign pin_digital_off_o[g] = pin_analog_i[g];
            assign pin_pullup_off_o[g]  = pin_analog_i[g];
        end
    endgenerate

    // Internal sources one at a time
    assign sel_amp_o    = (source_i == 2'b01);
    assign sel_bat_o    = (source_i == 2'b10);
    assign sel_supply_o = (source_i == 2'b11);

    // Reference: pin for 00 and 11
    assign ref_supply_o = (ref_i == adc_ctrl_pkg::REF_SUPPLY);
    assign ref_gain_o   = (ref_i == adc_ctrl_pkg::REF_GAIN);
    assign ref_pin_o    = !ref_supply_o && !ref_gain_o;
endmodule

// file: design/adc_control_registers.sv
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"

// Converter control registers, sequencer and result capture
module adc_control_registers (
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    // Avalon-MM slave
    input  wire logic [4:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    output logic [1:0]            avs_response,
    // Converter core
    input  wire logic [9:0]       conv_data_i,
    input  wire logic             lvr_enable_i,
    input  wire logic             irq_enable_i,
    input  wire logic [3:0]       pin_analog_i,
    output logic                  conv_power_o,
    output logic                  conv_sample_o,
    output logic                  conv_clk_en_o,
    output logic [1:0]            ref_gain_code_o,
    output logic [3:0]            pin_sel_o,
    output logic                  sel_amp_o,
    output logic                  sel_bat_o,
    output logic                  sel_supply_o,
    output logic                  ref_pin_o,
    output logic                  ref_supply_o,
    output logic                  ref_gain_o,
    output logic [3:0]            pin_digital_off_o,
    output logic [3:0]            pin_pullup_off_o,
    output logic                  bandgap_on_o,
    output logic                  irq_o
);
    // -----------------------------------------------------------------
    // Register state
    // -----------------------------------------------------------------
    logic [7:0]  ctrl_a_r;        // Start, power, align, gain lo, channel
    logic [7:0]  ctrl_b_r;        // Source, gain hi, reference, divider
    logic        bg_en_r;         // Bandgap enable bit
    logic        irq_flag_r;      // Completion request flag
    logic        busy_r;          // Conversion in progress
    logic [7:0]  res_lo_r;        // Result low byte
    logic [7:0]  res_hi_r;        // Result high byte
    logic [7:0]  rd_byte;         // Selected read byte
    logic        hit;             // Mapped address
    logic        wr_a;            // Write strobe control A
    logic        rd_ack_r;        // Read data loaded, answer this cycle
    logic [4:0]  tck_r;           // Conversion clock periods elapsed
    logic        tick;            // Conversion clock enable
    logic        start_seen_r;    // Start bit went high
    logic        launch;          // Start sequence completed
    logic        done;            // Last conversion period
    adc_ctrl_pkg::conv_state_t state_r;
    adc_ctrl_pkg::conv_state_t state_nxt;

    wire         pwr = ctrl_a_r[`ADC_A_PWR];
    wire [7:0]   wbyte = avs_writedata[7:0];
    wire         wen = avs_write && avs_byteenable[0];

    // -----------------------------------------------------------------
    // Bus slave: writes take one cycle, reads wait one for their data
    // -----------------------------------------------------------------
    // Read held off until the registered data stands on the bus
    assign avs_waitrequest = avs_read && !rd_ack_r;
    // Control A write strobe feeds the start detector
    assign wr_a = wen && (avs_address == {1'b0, `ADC_ADDR_CTRL_A});

    // Address decode
    always_comb begin
        hit = 1'b1;
        case (avs_address)
            {1'b0, `ADC_ADDR_RES_LO}:  rd_byte = res_lo_r;
            {1'b0, `ADC_ADDR_RES_HI}:  rd_byte = res_hi_r;
            {1'b0, `ADC_ADDR_CTRL_A}:  rd_byte = {ctrl_a_r[7], busy_r, ctrl_a_r[5:0]};
            {1'b0, `ADC_ADDR_CTRL_B}:  rd_byte = ctrl_b_r;
            `ADC_ADDR_BANDGAP:         rd_byte = {4'h0, bg_en_r, 3'h0};
            `ADC_ADDR_IRQ:             rd_byte = {7'h00, irq_flag_r};
            default: begin
                rd_byte = `ADC_ZERO8;
                hit     = 1'b0;
            end
        endcase
    end

    // Read data registered in the wait cycle, held until the next read
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_readdata <= `ADC_ZERO32;
            avs_response <= 2'b00;
            rd_ack_r     <= 1'b0;
        end else begin
            // Answer flag lives for one cycle of each read
            rd_ack_r <= avs_read && !rd_ack_r;
            if (avs_read && !rd_ack_r) begin
                // Unmapped reads return zero with an error code
                avs_readdata <= {24'h00_0000, rd_byte};
                avs_response <= hit ? 2'b00 : 2'b10;
            end
        end
    end

    // -----------------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_a_r <= `ADC_CTRL_RST;
            ctrl_b_r <= `ADC_CTRL_RST;
            bg_en_r  <= 1'b0;
        end else if (wen) begin
            case (avs_address)
                {1'b0, `ADC_ADDR_CTRL_A}: ctrl_a_r <= {wbyte[7], 1'b0, wbyte[5:0]};
                {1'b0, `ADC_ADDR_CTRL_B}: ctrl_b_r <= wbyte;
                `ADC_ADDR_BANDGAP:        bg_en_r  <= wbyte[`ADC_BG_EN];
                default: begin
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Start sequence detector: 0 -> 1 -> 0 written by software
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_seen_r <= 1'b0;
        end else if (wr_a) begin
            start_seen_r <= wbyte[`ADC_A_START];
        end
    end
    assign launch = wr_a && start_seen_r && !wbyte[`ADC_A_START] && pwr;

    // -----------------------------------------------------------------
    // Sequencer: 4 sample plus 10 convert periods
    // -----------------------------------------------------------------
    adc_clk_div #(
        .CNT_W (7)
    ) u_div (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (busy_r && pwr), // Ticks stop the cycle power drops
        .code_i    (ctrl_b_r[2:0]),
        .tick_o    (tick)
    );

    assign done = busy_r && tick && (tck_r == `ADC_TOTAL_TCK - 5'h01);

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            adc_ctrl_pkg::ST_IDLE: begin
                if (launch) state_nxt = adc_ctrl_pkg::ST_SAMPLE;
            end
            adc_ctrl_pkg::ST_SAMPLE: begin
                if (!pwr) state_nxt = adc_ctrl_pkg::ST_IDLE;
                else if (tick && tck_r == `ADC_SAMPLE_TCK - 5'h01) state_nxt = adc_ctrl_pkg::ST_CONVERT;
            end
            adc_ctrl_pkg::ST_CONVERT: begin
                if (!pwr || done) state_nxt = adc_ctrl_pkg::ST_IDLE;
            end
            default: state_nxt = adc_ctrl_pkg::ST_IDLE;
        endcase
    end

    // State, period count and busy flag
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= adc_ctrl_pkg::ST_IDLE;
            tck_r   <= 5'h00;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (launch && !busy_r) begin
                busy_r <= 1'b1;
                tck_r  <= 5'h00;
            end else if (done || !pwr) begin
                busy_r <= 1'b0;
                tck_r  <= 5'h00;
            end else if (busy_r && tick) begin
                tck_r  <= tck_r + 5'h01;
            end
        end
    end

    // -----------------------------------------------------------------
    // Result capture, both bytes in the busy-clear cycle
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            res_lo_r <= `ADC_ZERO8;
            res_hi_r <= `ADC_ZERO8;
        end else if (done && pwr) begin
            if (ctrl_a_r[`ADC_A_ALIGN]) begin
                res_hi_r <= {6'h00, conv_data_i[9:8]};
                res_lo_r <= conv_data_i[7:0];
            end else begin
                res_hi_r <= conv_data_i[9:2];
                res_lo_r <= {conv_data_i[1:0], 6'h00};
            end
        end
    end

    // -----------------------------------------------------------------
    // Completion request flag: set wins over software clear
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_flag_r <= 1'b0;
        end else if (done) begin
            irq_flag_r <= 1'b1;
        end else if (wen && avs_address == `ADC_ADDR_IRQ && wbyte[0]) begin
            irq_flag_r <= 1'b0;
        end
    end
    assign irq_o = irq_flag_r && irq_enable_i;

    // -----------------------------------------------------------------
    // Analog side controls
    // -----------------------------------------------------------------
    assign conv_power_o    = pwr;
    assign conv_sample_o   = (state_r == adc_ctrl_pkg::ST_SAMPLE);
    assign conv_clk_en_o   = tick;
    assign ref_gain_code_o = {ctrl_b_r[`ADC_B_GAIN_HI], ctrl_a_r[`ADC_A_GAIN_LO]};
    assign bandgap_on_o    = bg_en_r || lvr_enable_i;

    adc_input_mux u_mux (
        .source_i          (ctrl_b_r[7:6]),
        .chan_i            (ctrl_a_r[2:0]),
        .ref_i             (ctrl_b_r[4:3]),
        .pin_analog_i      (pin_analog_i),
        .pin_sel_o         (pin_sel_o),
        .sel_amp_o         (sel_amp_o),
        .sel_bat_o         (sel_bat_o),
        .sel_supply_o      (sel_supply_o),
        .ref_pin_o         (ref_pin_o),
        .ref_supply_o      (ref_supply_o),
        .ref_gain_o        (ref_gain_o),
        .pin_digital_off_o (pin_digital_off_o),
        .pin_pullup_off_o  (pin_pullup_off_o)
    );
endmodule

// file: tb/adc_ctrl_props.sv
`timescale 1ns/1ps
// Watches the converter control ports
module adc_ctrl_props (
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        lvr_enable_i,
    input wire logic        irq_enable_i,
    input wire logic [3:0]  pin_analog_i,
    input wire logic        conv_power_o,
    input wire logic        conv_sample_o,
    input wire logic        conv_clk_en_o,
    input wire logic [3:0]  pin_sel_o,
    input wire logic        sel_amp_o,
    input wire logic        sel_bat_o,
    input wire logic        sel_supply_o,
    input wire logic        ref_pin_o,
    input wire logic        ref_supply_o,
    input wire logic        ref_gain_o,
    input wire logic [3:0]  pin_digital_off_o,
    input wire logic [3:0]  pin_pullup_off_o,
    input wire logic        bandgap_on_o,
    input wire logic        irq_o
);
    // ----------------------------------------
    // Checks on one clock domain
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    upper_zero_a: assert property (avs_read |=> avs_readdata[31:8] == 24'h00_0000) else $error("read upper bits set");
    pin_release_a: assert property (pin_digital_off_o == pin_analog_i && pin_pullup_off_o == pin_analog_i)
        else $error("pin release mismatch");
    lvr_bandgap_a: assert property (lvr_enable_i |-> bandgap_on_o) else $error("bandgap off with lvr");
    bg_write_a: assert property (avs_write && avs_address == 5'h10 && avs_byteenable[0] && avs_writedata[3]
        |=> bandgap_on_o) else $error("bandgap bit write lost");
    irq_gate_a: assert property (irq_o |-> irq_enable_i) else $error("irq without enable");
    src_excl_a: assert property ($onehot0({sel_amp_o, sel_bat_o, sel_supply_o})) else $error("two sources");
    ref_one_a: assert property ($onehot({ref_pin_o, ref_supply_o, ref_gain_o})) else $error("reference select");
    pin_excl_a: assert property ($onehot0(pin_sel_o)) else $error("two pins routed");
    clk_power_a: assert property (conv_clk_en_o |-> conv_power_o) else $error("tick while off");
    sample_len_a: assert property ($rose(conv_sample_o) |-> conv_sample_o [*4]) else $error("short sample");
endmodule

// file: tb/adc_control_registers_tb_top.sv
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

// Self-checking bench for the converter control block
module adc_control_registers_tb_top;
    // Row of expected routing for one register pair
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [3:0] pin;
        logic [2:0] src;
        logic [2:0] rsel;
        logic [1:0] gain;
    } row_t;
    logic        mclk_i = 1'b0;           // System clock
    logic        sys_rst_i = 1'b1;        // Async reset
    logic [4:0]  avs_address = 5'h00;     // Bus request
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic [9:0]  conv_data_i = 10'h000;   // Converter result
    logic        lvr_enable_i = 1'b0;
    logic        irq_enable_i = 1'b1;
    logic [3:0]  pin_analog_i = 4'h5;
    logic        conv_power_o, conv_sample_o, conv_clk_en_o, sel_amp_o, sel_bat_o, sel_supply_o;
    logic        ref_pin_o, ref_supply_o, ref_gain_o, bandgap_on_o, irq_o;
    logic [1:0]  ref_gain_code_o;
    logic [3:0]  pin_sel_o, pin_digital_off_o, pin_pullup_off_o;
    int          n_errors = 0;
    int          num_checks = 0;
    logic [31:0] q;                       // Last read data
    logic [7:0]  exp_lo, exp_hi;          // Expected result bytes
    logic [3:0]  avs_byteenable = 4'hF;   // Byte lanes
    row_t        rows [8] = '{'{8'h00, 8'h00, 4'h1, 3'h0, 3'h4, 2'h0}, '{8'h09, 8'h08, 4'h2, 3'h0, 3'h2, 2'h1},
                              '{8'h02, 8'h30, 4'h4, 3'h0, 3'h1, 2'h2}, '{8'h0B, 8'h38, 4'h8, 3'h0, 3'h4, 2'h3},
                              '{8'h04, 8'h40, 4'h0, 3'h4, 3'h4, 2'h0}, '{8'h05, 8'h80, 4'h0, 3'h2, 3'h4, 2'h0},
                              '{8'h06, 8'hC0, 4'h0, 3'h1, 3'h4, 2'h0}, '{8'h07, 8'h00, 4'h0, 3'h0, 3'h4, 2'h0}};

    adc_control_registers i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .conv_data_i(conv_data_i), .lvr_enable_i(lvr_enable_i), .irq_enable_i(irq_enable_i),
        .pin_analog_i(pin_analog_i), .conv_power_o(conv_power_o), .conv_sample_o(conv_sample_o),
        .conv_clk_en_o(conv_clk_en_o), .ref_gain_code_o(ref_gain_code_o), .pin_sel_o(pin_sel_o),
        .sel_amp_o(sel_amp_o), .sel_bat_o(sel_bat_o), .sel_supply_o(sel_supply_o), .ref_pin_o(ref_pin_o),
        .ref_supply_o(ref_supply_o), .ref_gain_o(ref_gain_o), .pin_digital_off_o(pin_digital_off_o),
        .pin_pullup_off_o(pin_pullup_off_o), .bandgap_on_o(bandgap_on_o), .irq_o(irq_o));

    // Clock at 125 MHz
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end

    // One bus transfer, data taken at the edge waitrequest is low, then one idle edge
    task automatic bus(input logic wr, input logic [4:0] adr, input logic [7:0] d);
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h00_0000, d};
        do @(posedge mclk_i); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk_i);
    endtask

    // Full conversion at one divider code and alignment
    task automatic conv(input logic [2:0] code, input logic al, input logic [9:0] d);
        int   t;
        logic first;
        conv_data_i <= d;
        bus(1'b1, `ADC_ADDR_CTRL_B, {5'h00, code});
        bus(1'b1, `ADC_ADDR_CTRL_A, {3'b101, al, 4'h4});
        bus(1'b1, `ADC_ADDR_CTRL_A, {3'b001, al, 4'h4});
        t = 0;
        do begin
            bus(1'b0, `ADC_ADDR_CTRL_A, 8'h00);
            if (t == 0) first = q[6];
            t += 3;
        end while (q[6] === 1'b1 && t < 4000);
        `CHK(first, 1'b1)
        `CHK((t >= (14 << code) + 2) && (t <= (14 << code) + 4), 1'b1)
        exp_hi = al ? {6'h00, d[9:8]} : d[9:2];
        exp_lo = al ? d[7:0] : {d[1:0], 6'h00};
        bus(1'b0, `ADC_ADDR_RES_LO, 8'h00);
        `CHK(q[7:0], exp_lo)
        bus(1'b0, `ADC_ADDR_RES_HI, 8'h00);
        `CHK(q[7:0], exp_hi)
        $display("conversion code %0d done", code);
    endtask

    // Prints the counts and verdict, then stops
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog cuts a hang short
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        bus(1'b0, `ADC_ADDR_CTRL_A, 8'h00);
        `CHK(q[7:0], 8'h00)
        foreach (rows[i]) begin
            bus(1'b1, `ADC_ADDR_CTRL_A, rows[i].a);
            bus(1'b1, `ADC_ADDR_CTRL_B, rows[i].b);
            bus(1'b0, `ADC_ADDR_CTRL_B, 8'h00);
            `CHK(q[7:0], rows[i].b)
            `CHK(pin_sel_o, rows[i].pin)
            `CHK({sel_amp_o, sel_bat_o, sel_supply_o}, rows[i].src)
            `CHK({ref_pin_o, ref_supply_o, ref_gain_o}, rows[i].rsel)
            `CHK(ref_gain_code_o, rows[i].gain)
        end
        $display("routing rows done");
        for (int c = 0; c < 8; c++) conv(3'(c), c[0], 10'(10'h2B5 + 10'(c * 57)));
        `CHK(irq_o, 1'b1)
        bus(1'b1, `ADC_ADDR_IRQ, 8'h01);
        `CHK(irq_o, 1'b0)
        bus(1'b1, `ADC_ADDR_CTRL_A, 8'h60);
        repeat (20) @(posedge mclk_i);
        bus(1'b0, `ADC_ADDR_CTRL_A, 8'h00);
        `CHK(q[7:0], 8'h20)
        conv_data_i <= 10'h3C3;
        bus(1'b1, `ADC_ADDR_CTRL_A, 8'h80);
        bus(1'b1, `ADC_ADDR_CTRL_A, 8'h00);
        repeat (40) @(posedge mclk_i);
        bus(1'b0, `ADC_ADDR_CTRL_A, 8'h00);
        `CHK(q[7:0], 8'h00)
        bus(1'b1, `ADC_ADDR_CTRL_B, 8'h07);
        bus(1'b1, `ADC_ADDR_CTRL_A, 8'hA0);
        bus(1'b1, `ADC_ADDR_CTRL_A, 8'h20);
        repeat (700) @(posedge mclk_i);
        bus(1'b1, `ADC_ADDR_CTRL_A, 8'h00);
        repeat (2000) @(posedge mclk_i);
        bus(1'b0, `ADC_ADDR_RES_LO, 8'h00);
        `CHK(q[7:0], exp_lo)
        bus(1'b0, `ADC_ADDR_RES_HI, 8'h00);
        `CHK(q[7:0], exp_hi)
        bus(1'b1, `ADC_ADDR_BANDGAP, 8'h08);
        bus(1'b0, `ADC_ADDR_BANDGAP, 8'h00);
        `CHK(q[7:0], 8'h08)
        bus(1'b1, `ADC_ADDR_BANDGAP, 8'h00);
        lvr_enable_i <= 1'b1;
        pin_analog_i <= 4'hA;
        bus(1'b0, 5'h18, 8'h00);
        `CHK({avs_response, q}, {2'b10, 32'h0000_0000})
        `CHK(bandgap_on_o, 1'b1)
        lvr_enable_i <= 1'b0;
        bus(1'b0, `ADC_ADDR_BANDGAP, 8'h00);
        `CHK(bandgap_on_o, 1'b0)
        avs_byteenable <= 4'h0;
        bus(1'b1, `ADC_ADDR_CTRL_B, 8'hA5);
        avs_byteenable <= 4'hF;
        bus(1'b0, `ADC_ADDR_CTRL_B, 8'h00);
        `CHK(q[7:0], 8'h07)
        bus(1'b1, `ADC_ADDR_CTRL_A, 8'h2B);
        bus(1'b1, `ADC_ADDR_BANDGAP, 8'h08);
        sys_rst_i <= 1'b1;
        @(posedge mclk_i);
        `CHK({bandgap_on_o, conv_power_o, ref_pin_o, ref_gain_code_o, pin_sel_o}, 9'h041)
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        bus(1'b0, `ADC_ADDR_CTRL_B, 8'h00);
        `CHK(q[7:0], 8'h00)
        $display("hand tests done");
        stop_test();
    end
endmodule

bind adc_control_registers adc_ctrl_props i_props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .lvr_enable_i(lvr_enable_i),
    .irq_enable_i(irq_enable_i), .pin_analog_i(pin_analog_i), .conv_power_o(conv_power_o),
    .conv_sample_o(conv_sample_o), .conv_clk_en_o(conv_clk_en_o), .pin_sel_o(pin_sel_o),
    .sel_amp_o(sel_amp_o), .sel_bat_o(sel_bat_o), .sel_supply_o(sel_supply_o), .ref_pin_o(ref_pin_o),
    .ref_supply_o(ref_supply_o), .ref_gain_o(ref_gain_o), .pin_digital_off_o(pin_digital_off_o),
    .pin_pullup_off_o(pin_pullup_off_o), .bandgap_on_o(bandgap_on_o), .irq_o(irq_o));
